//--- oss_loader.sv
// OTP shadow loader top: load engine, shadow file and host registers
`timescale 1ns/1ps
module oss_loader (
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          wakeup,
	input  wire logic [oss_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [oss_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [oss_pkg::DATA_W-1:0]    reg_rdata,
	output logic                               irq,
	output logic                               otp_rd_req,
	output logic      [oss_pkg::BLK_W-1:0]     otp_rd_blk,
	output logic      [oss_pkg::MODE_W-1:0]    otp_margin,
	input  wire logic                          otp_rd_valid,
	input  wire logic [oss_pkg::CODE_W-1:0]    otp_rd_code,
	output logic      [oss_pkg::SHADOW_W-1:0]  shadow_image,
	output logic                               load_busy
);
	import oss_pkg::*;

	oss_state_t          state;
	oss_state_t          next_state;
	logic [BLK_W-1:0]    next_blk;
	logic                next_req;
	logic [MODE_W-1:0]   next_margin;
	logic [SHADOW_W-1:0] next_shadow;
	logic                next_busy;

	logic [MODE_W-1:0]   margin_read_select;
	logic [MODE_W-1:0]   next_mode;
	logic [DATA_W-1:0]   fault;
	logic [DATA_W-1:0]   next_fault;
	logic [DATA_W-1:0]   mask;
	logic [DATA_W-1:0]   next_mask;
	logic [BLK_W-1:0]    corrected_block_location;
	logic [BLK_W-1:0]    next_sec_loc;
	logic [BLK_W-1:0]    uncorrectable_block_location;
	logic [BLK_W-1:0]    next_ded_loc;
	logic [DATA_W-1:0]   next_rdata;
	logic                next_irq;

	logic [DATA_BITS-1:0]    dec_data;
	logic                    dec_single;
	logic                    dec_double;
	logic                    ev_sec;
	logic                    ev_ded;
	logic                    ev_done;
	logic                    go_wr;
	logic                    in_shadow;
	logic [SHADOW_IDX_W-1:0] sidx;

	oss_secded_dec u_dec (
		.code   (otp_rd_code),
		.data   (dec_data),
		.single (dec_single),
		.double (dec_double)
	);

	assign in_shadow = reg_addr <= ADDR_SHADOW_LAST;
	assign sidx      = reg_addr[SHADOW_IDX_W-1:0];
	assign go_wr     = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_GO_BIT];

	// Load engine and shadow file
	always_comb begin
		next_state  = state;
		next_blk    = otp_rd_blk;
		next_req    = 1'h0;
		next_margin = otp_margin;
		next_shadow = shadow_image;
		ev_sec      = 1'h0;
		ev_ded      = 1'h0;
		ev_done     = 1'h0;
		if (wakeup || (go_wr && state == OSS_IDLE)) begin
			next_shadow = SHADOW_DEFAULT;
			next_blk    = '0;
			next_state  = OSS_REQ;
			if (wakeup) begin
				next_margin = MARGIN_NORMAL;
			end else begin
				next_margin = reg_wdata[CTRL_MODE_LSB +: MODE_W];
			end
		end else begin
			unique case (state)
				OSS_IDLE: begin
					if (reg_wr && in_shadow) begin
						next_shadow[sidx*DATA_W +: DATA_W] = reg_wdata;
					end
				end
				OSS_REQ: begin
					next_req   = 1'h1;
					next_state = OSS_WAIT;
				end
				OSS_WAIT: begin
					if (otp_rd_valid) begin
						if (!dec_double) begin
							// Clean and corrected blocks load alike
							next_shadow[otp_rd_blk*DATA_BITS +: DATA_BITS] = dec_data;
						end
						ev_sec = dec_single;
						ev_ded = dec_double;
						if (otp_rd_blk == LAST_BLK) begin
							next_state = OSS_IDLE;
							ev_done    = 1'h1;
						end else begin
							next_blk   = BLK_W'(otp_rd_blk + 3'h1);
							next_state = OSS_REQ;
						end
					end
				end
				// Unused state code falls back to idle
				default: next_state = OSS_IDLE;
			endcase
		end
		next_busy = next_state != OSS_IDLE;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state        <= OSS_IDLE;
			otp_rd_blk   <= '0;
			otp_rd_req   <= 1'h0;
			otp_margin   <= MARGIN_NORMAL;
			shadow_image <= SHADOW_DEFAULT;
			load_busy    <= 1'h0;
		end else begin
			state        <= next_state;
			otp_rd_blk   <= next_blk;
			otp_rd_req   <= next_req;
			otp_margin   <= next_margin;
			shadow_image <= next_shadow;
			load_busy    <= next_busy;
		end
	end

	// Host registers, fault flags and interrupt
	always_comb begin
		next_mode    = margin_read_select;
		next_mask    = mask;
		next_fault   = fault;
		next_sec_loc = corrected_block_location;
		next_ded_loc = uncorrectable_block_location;
		next_rdata   = '0;
		if (reg_wr) begin
			if (reg_addr == ADDR_CTRL) begin
				next_mode = reg_wdata[CTRL_MODE_LSB +: MODE_W];
			end
			if (reg_addr == ADDR_MASK) begin
				next_mask = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (in_shadow) begin
				next_rdata = shadow_image[sidx*DATA_W +: DATA_W];
			end else begin
				unique case (reg_addr)
					ADDR_CTRL:    next_rdata = {5'h00, margin_read_select};
					ADDR_FAULT:   next_rdata = fault;
					ADDR_MASK:    next_rdata = mask;
					ADDR_SEC_LOC: next_rdata = {5'h00, corrected_block_location};
					ADDR_DED_LOC: next_rdata = {5'h00, uncorrectable_block_location};
					ADDR_STATUS:  next_rdata = {7'h00, load_busy};
					default:      next_rdata = '0;
				endcase
			end
			if (reg_addr == ADDR_FAULT) begin
				next_fault = FAULT_RST;
			end
		end
		// Set after clear so an event never gets lost
		if (ev_sec) begin
			next_fault[FLT_SEC_BIT] = 1'h1;
			next_sec_loc            = otp_rd_blk;
		end
		if (ev_ded) begin
			next_fault[FLT_DED_BIT] = 1'h1;
			next_ded_loc            = otp_rd_blk;
		end
		if (ev_done) begin
			next_fault[FLT_DONE_BIT] = 1'h1;
		end
		next_irq = |(next_fault & next_mask);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			margin_read_select           <= MODE_RST;
			mask                         <= MASK_RST;
			fault                        <= FAULT_RST;
			corrected_block_location     <= LOC_RST;
			uncorrectable_block_location <= LOC_RST;
			reg_rdata                    <= '0;
			irq                          <= 1'h0;
		end else begin
			margin_read_select           <= next_mode;
			mask                         <= next_mask;
			fault                        <= next_fault;
			corrected_block_location     <= next_sec_loc;
			uncorrectable_block_location <= next_ded_loc;
			reg_rdata                    <= next_rdata;
			irq                          <= next_irq;
		end
	end
endmodule

//--- oss_loader_chk.sv
// Port-level checker for the OTP shadow loader
`timescale 1ns/1ps
module oss_loader_chk import oss_pkg::*; (
	input wire logic                ref_clk,
	input wire logic                rst,
	input wire logic                wakeup,
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic [DATA_W-1:0]   reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [DATA_W-1:0]   reg_rdata,
	input wire logic                otp_rd_req,
	input wire logic [BLK_W-1:0]    otp_rd_blk,
	input wire logic [MODE_W-1:0]   otp_margin,
	input wire logic                otp_rd_valid,
	input wire logic [SHADOW_W-1:0] shadow_image,
	input wire logic                load_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_req_pulse;
		otp_rd_req |=> !otp_rd_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("long request");
	property p_wake_dflt;
		wakeup |=> load_busy && shadow_image == SHADOW_DEFAULT;
	endproperty
	a_wake_dflt: assert property (p_wake_dflt) else $error("no defaults");
	property p_wake_req;
		wakeup |-> ##2 otp_rd_req && otp_rd_blk == 3'h0 && otp_margin == MARGIN_NORMAL;
	endproperty
	a_wake_req: assert property (p_wake_req) else $error("bad first read");
	property p_next_blk;
		otp_rd_valid && load_busy && otp_rd_blk != LAST_BLK |=>
			##1 otp_rd_req && otp_rd_blk == $past(otp_rd_blk, 2) + 3'h1;
	endproperty
	a_next_blk: assert property (p_next_blk) else $error("bad next block");
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
	property p_idle_hold;
		!load_busy && !wakeup && !reg_wr |=> $stable(shadow_image);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("shadow changed");
	property p_go;
		reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_GO_BIT] && !load_busy |=>
			load_busy ##1 otp_rd_req && otp_margin == $past(reg_wdata[MODE_W-1:0], 2);
	endproperty
	a_go: assert property (p_go) else $error("bad margin reload");
	property p_busy_end;
		$fell(load_busy) |-> $past(otp_rd_valid) || $past(otp_rd_valid, 2);
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("early end");
endmodule
bind oss_loader oss_loader_chk i_oss_loader_chk (.ref_clk(ref_clk), .rst(rst),
	.wakeup(wakeup), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd_req(otp_rd_req), .otp_rd_blk(otp_rd_blk),
	.otp_margin(otp_margin), .otp_rd_valid(otp_rd_valid), .shadow_image(shadow_image),
	.load_busy(load_busy));

//--- oss_otp_model.sv
// OTP array model answering block reads with coded words
`timescale 1ns/1ps
module oss_otp_model (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             req,
	input  wire logic [2:0]       blk,
	input  wire logic             slow,
	input  wire logic [5:0][71:0] flip,
	output logic                  valid,
	output logic      [71:0]      code
);
	int cnt;
	function automatic logic [71:0] enc(input logic [2:0] b);
		logic [71:0] c;
		logic [7:0]  v;
		int          j;
		c = '0;
		j = 0;
		for (int i = 3; i < 72; i++) begin
			if ((i & (i - 1)) != 0) begin
				v = 8'(b * 16 + j / 8) ^ 8'h5a;
				c[i] = v[j % 8];
				j++;
			end
		end
		for (int p = 1; p < 72; p = p * 2) begin
			for (int i = p + 1; i < 72; i++) begin
				if ((i & p) != 0) c[p] ^= c[i];
			end
		end
		c[0] = ^c;
		return c;
	endfunction
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			valid <= 0;
			cnt <= 0;
			code <= '0;
		end else begin
			valid <= !req && cnt == 1;
			code <= (!req && cnt == 1) ? enc(blk) ^ flip[blk] : ~code;
			cnt <= req ? (slow ? 5 : 1) : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule

//--- oss_pkg.sv
// Constants, types and register map of the OTP shadow loader
package oss_pkg;
	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 8;
	localparam int NUM_BLOCKS   = 6;
	localparam int BLK_W        = 3;
	localparam int CODE_W       = 72;
	localparam int DATA_BITS    = 64;
	localparam int SYN_W        = 7;
	localparam int MODE_W       = 3;
	localparam int SHADOW_BYTES = 48;
	localparam int SHADOW_W     = 384;
	localparam int SHADOW_IDX_W = 6;

	localparam logic [ADDR_W-1:0] ADDR_SHADOW_LAST = 8'h2f;
	localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_FAULT       = 8'h31;
	localparam logic [ADDR_W-1:0] ADDR_MASK        = 8'h32;
	localparam logic [ADDR_W-1:0] ADDR_SEC_LOC     = 8'h33;
	localparam logic [ADDR_W-1:0] ADDR_DED_LOC     = 8'h34;
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h35;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_GO_BIT   = 3;
	localparam int FLT_SEC_BIT   = 0;
	localparam int FLT_DED_BIT   = 1;
	localparam int FLT_DONE_BIT  = 2;
	localparam int STAT_BUSY_BIT = 0;

	localparam logic [MODE_W-1:0]   MODE_RST       = 3'h0;
	localparam logic [MODE_W-1:0]   MARGIN_NORMAL  = 3'h0;
	localparam logic [DATA_W-1:0]   MASK_RST       = 8'h00;
	localparam logic [DATA_W-1:0]   FAULT_RST      = 8'h00;
	localparam logic [BLK_W-1:0]    LOC_RST        = 3'h0;
	localparam logic [BLK_W-1:0]    LAST_BLK       = 3'h5;
	localparam logic [SHADOW_W-1:0] SHADOW_DEFAULT = '0;

	typedef enum logic [1:0] {
		OSS_IDLE,
		OSS_REQ,
		OSS_WAIT
	} oss_state_t;
endpackage

//--- oss_secded_dec.sv
// Combinational (72,64) SECDED decoder
`timescale 1ns/1ps
module oss_secded_dec (
	input  wire logic [oss_pkg::CODE_W-1:0]    code,
	output logic      [oss_pkg::DATA_BITS-1:0] data,
	output logic                               single,
	output logic                               double
);
	import oss_pkg::*;

	logic [SYN_W-1:0]  syn;
	logic              par;
	logic [CODE_W-1:0] fixed;

	always_comb begin
		int j;
		j = 0;
		syn = '0;
		data = '0;
		par = ^code;
		for (int i = 1; i < CODE_W; i++) begin
			for (int k = 0; k < SYN_W; k++) begin
				if (((i >> k) & 1) == 1) begin
					syn[k] = syn[k] ^ code[i];
				end
			end
		end
		fixed = code;
		if (par && syn != '0 && int'(syn) < CODE_W) begin
			fixed[syn] = ~fixed[syn];
		end
		for (int i = 1; i < CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				data[j] = fixed[i];
				j = j + 1;
			end
		end
		// Syndrome beyond the block can only come from a multi-bit error
		single = par && int'(syn) < CODE_W;
		double = (!par && syn != '0) || (par && int'(syn) >= CODE_W);
	end
endmodule

//--- tb_oss_loader.sv
// Self-checking bench for the OTP shadow loader
`timescale 1ns/1ps
module tb_oss_loader;
	import oss_pkg::*;
	logic                ref_clk = 0, rst = 1, wakeup = 0, reg_wr = 0, reg_rd = 0, slow = 0;
	logic [ADDR_W-1:0]   reg_addr = '0;
	logic [DATA_W-1:0]   reg_wdata = '0, reg_rdata;
	logic                irq, otp_rd_req, otp_rd_valid, load_busy;
	logic [BLK_W-1:0]    otp_rd_blk;
	logic [MODE_W-1:0]   otp_margin;
	logic [CODE_W-1:0]   otp_rd_code;
	logic [SHADOW_W-1:0] shadow_image;
	logic [5:0][71:0]    flip = '0;
	int                  miscompares = 0, compares = 0;
	always #12.5 ref_clk = ~ref_clk;
	oss_loader i_oss_loader (.ref_clk(ref_clk), .rst(rst), .wakeup(wakeup), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.otp_rd_req(otp_rd_req), .otp_rd_blk(otp_rd_blk), .otp_margin(otp_margin),
		.otp_rd_valid(otp_rd_valid), .otp_rd_code(otp_rd_code), .shadow_image(shadow_image),
		.load_busy(load_busy));
	oss_otp_model i_oss_otp_model (.clk(ref_clk), .rst(rst), .req(otp_rd_req), .blk(otp_rd_blk),
		.slow(slow), .flip(flip), .valid(otp_rd_valid), .code(otp_rd_code));
	task automatic chk(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge ref_clk);
		reg_wr <= 0;
		@(posedge ref_clk);
	endtask
	task automatic rc(input string n, input logic [7:0] a, e);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 chk(n, reg_rdata, e);
		@(posedge ref_clk);
	endtask
	task automatic wait_idle();
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 400 && load_busy !== 1'b0; i++) @(posedge ref_clk);
		if (load_busy !== 1'b0) begin
			miscompares++;
			tally_and_finish();
		end
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic wake();
		wakeup <= 1;
		@(posedge ref_clk);
		wakeup <= 0;
		wait_idle();
	endtask
	// Whole image; the skipped block must keep zero defaults
	task automatic chk_img(input int bad);
		for (int n = 0; n < SHADOW_BYTES; n++)
			chk("shadow", shadow_image[8*n+:8],
				(n / 8 == bad) ? 8'h00 : (8'(n / 8 * 16 + n % 8) ^ 8'h5a));
	endtask
	task automatic t_clean();
		wake();
		chk_img(9);
		rc("fault", ADDR_FAULT, 8'h04);
	endtask
	task automatic t_single();
		// Data bit in block 1, parity bit p64 in block 4
		flip <= {72'h0, 72'h1 << 64, {2{72'h0}}, 72'h1 << 9, 72'h0};
		slow <= 1;
		wr(ADDR_MASK, 8'h01);
		wake();
		chk_img(9);
		chk("irq", irq, 8'h01);
		rc("fault", ADDR_FAULT, 8'h05);
		rc("sec_loc", ADDR_SEC_LOC, 8'h04);
		rc("mask", ADDR_MASK, 8'h01);
		chk("irq", irq, 8'h00);
	endtask
	task automatic t_double();
		flip <= {{3{72'h0}}, (72'h1 << 10) | (72'h1 << 40), {2{72'h0}}};
		slow <= 0;
		wr(ADDR_CTRL, 8'h0d);
		// Shadow write during the reload must be dropped
		wr(8'h10, 8'hff);
		rc("busy", ADDR_STATUS, 8'h01);
		wait_idle();
		chk_img(2);
		rc("fault", ADDR_FAULT, 8'h06);
		rc("ded_loc", ADDR_DED_LOC, 8'h02);
		rc("ctrl", ADDR_CTRL, 8'h05);
	endtask
	task automatic t_regs();
		wr(8'h05, 8'h3c);
		rc("shadow_rw", 8'h05, 8'h3c);
		chk("image", shadow_image[47:40], 8'h3c);
		rc("unmapped", 8'h40, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		t_clean();
		t_single();
		t_double();
		t_regs();
		tally_and_finish();
	end
endmodule
